// file: inc/flow_valve_pkg.sv
// Constants, register map and field layout of the valve controller block
// Assumes an AXI4-Lite master with 32-bit data and a 100 MHz aclk
package flow_valve_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_SETPOINT = 8'h04;
    localparam logic [7:0] OFF_GAIN = 8'h08;
    localparam logic [7:0] OFF_TINT = 8'h0c;
    localparam logic [7:0] OFF_LIFT = 8'h10;
    localparam logic [7:0] OFF_RAMP = 8'h14;
    localparam logic [7:0] OFF_FFWD = 8'h18;
    localparam logic [7:0] OFF_BFTHR = 8'h1c;
    localparam logic [7:0] OFF_ALARM = 8'h20;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFF_NV_CMD = 8'h2c;
    localparam logic [7:0] OFF_DRIVE = 8'h30;
    // Fields of config_register
    localparam int CFG_STORE_AUTO = 0;
    localparam int CFG_BF_EN = 1;
    localparam int CFG_FMT_LSB = 4;
    localparam int CFG_FMT_W = 3;
    // Output formats; live-zero formats are 1..3
    localparam logic [2:0] FMT_0_20MA = 3'h0;
    localparam logic [2:0] FMT_4_20MA = 3'h1;
    localparam logic [2:0] FMT_1_5V = 3'h2;
    localparam logic [2:0] FMT_2_10V = 3'h3;
    // Reset values
    localparam logic [31:0] RST_CONFIG = 32'h0000_0011;
    localparam logic [15:0] RST_GAIN = 16'h0100;
    localparam logic [15:0] RST_TINT = 16'h0010;
    localparam logic [15:0] RST_LIFT = 16'h0000;
    localparam logic [7:0] RST_RAMP = 8'h00;
    localparam logic [15:0] RST_FFWD = 16'h0000;
    localparam logic [15:0] RST_BFTHR = 16'h0000;
    // Analog and flow scale, full scale is 16'hffff
    localparam logic [15:0] FULL_SCALE = 16'hffff;
    localparam logic [15:0] BF_THR_MAX = 16'h3333; // One fifth of full scale
    localparam logic [15:0] LIVE_ZERO_MIN = 16'h3333; // 20 % of span, e.g. 4 mA of 20 mA
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_US = 100;
    localparam int SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
    // Interrupt status bits
    localparam int IRQ_BF = 0;
    localparam int IRQ_NV_DONE = 1;
    // Event of the nv command register
    localparam int NV_UPDATE = 0;
endpackage : flow_valve_pkg

// file: src/flow_valve_control_backflow.sv
// Valve controller with backflow alarms and non-volatile save control
// Assumes an AXI4-Lite master, synchronous reset, and flow input from another domain
`timescale 1ns/1ns
`default_nettype none
module flow_valve_control_backflow
    import flow_valve_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC,
    parameter int NV_COUNT = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [16:0] flow_meas,
    output logic [15:0] valve_drive,
    output logic [15:0] analog_out,
    output logic nv_write,
    output logic [3:0] nv_index,
    output logic [31:0] nv_data,
    input wire logic nv_busy,
    output logic irq
);
    localparam int SMP_W = $clog2(SAMPLE_CYCLES + 1);

    logic [31:0] config_q;
    logic [15:0] setpoint_q, gain_q, tint_q, lift_q, ffwd_q, bfthr_q;
    logic [7:0] ramp_q;
    logic [1:0] irq_stat_q, irq_mask_q;
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic signed [16:0] flow_s1_q, flow_s2_q;
    logic nv_busy_s1_q, nv_busy_s2_q;
    logic [SMP_W-1:0] smp_cnt_q;
    logic tick;
    logic signed [31:0] integ_q;
    logic [15:0] drive_q, ramp_lvl_q;
    logic flag0_q, flag1_q;
    logic nv_pend_q, nv_run_q;
    logic [3:0] nv_idx_q;
    logic persist_wr;
    logic [1:0] irq_ev;

    // Merge new bytes of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction : merge

    // Persistable register image by index
    function automatic logic [31:0] nv_word(input logic [3:0] i, input logic [31:0] c,
        input logic [15:0] g, input logic [15:0] t, input logic [15:0] l,
        input logic [7:0] r, input logic [15:0] f, input logic [15:0] b);
        case (i)
            4'h0: nv_word = c;
            4'h1: nv_word = {16'h0000, g};
            4'h2: nv_word = {16'h0000, t};
            4'h3: nv_word = {16'h0000, l};
            4'h4: nv_word = {24'h000000, r};
            4'h5: nv_word = {16'h0000, f};
            4'h6: nv_word = {16'h0000, b};
            default: nv_word = 32'h0000_0000;
        endcase
    endfunction : nv_word

    // Write address and data capture, either order
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign wr_go = aw_q && w_q && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_bresp = 2'b00;

    // Software-written registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            config_q <= RST_CONFIG;
            setpoint_q <= 16'h0000;
            gain_q <= RST_GAIN;
            tint_q <= RST_TINT;
            lift_q <= RST_LIFT;
            ramp_q <= RST_RAMP;
            ffwd_q <= RST_FFWD;
            bfthr_q <= RST_BFTHR;
            irq_mask_q <= 2'b00;
        end
        else if (wr_go)
        begin
            case (awaddr_q)
                OFF_CONFIG: config_q <= merge(config_q, wdata_q, wstrb_q);
                OFF_SETPOINT: setpoint_q <= 16'(merge({16'h0000, setpoint_q}, wdata_q, wstrb_q));
                OFF_GAIN: gain_q <= 16'(merge({16'h0000, gain_q}, wdata_q, wstrb_q));
                OFF_TINT: tint_q <= 16'(merge({16'h0000, tint_q}, wdata_q, wstrb_q));
                OFF_LIFT: lift_q <= 16'(merge({16'h0000, lift_q}, wdata_q, wstrb_q));
                OFF_RAMP: ramp_q <= 8'(merge({24'h000000, ramp_q}, wdata_q, wstrb_q));
                OFF_FFWD: ffwd_q <= 16'(merge({16'h0000, ffwd_q}, wdata_q, wstrb_q));
                // Threshold limited to one fifth of full scale
                OFF_BFTHR: bfthr_q <= (wdata_q[15:0] > BF_THR_MAX) ? BF_THR_MAX : wdata_q[15:0];
                OFF_IRQ_MASK: irq_mask_q <= wdata_q[1:0];
                default: ;
            endcase
        end
    end

    // Read channel, one cycle to answer
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                OFF_CONFIG: s_axi_rdata <= config_q;
                OFF_SETPOINT: s_axi_rdata <= {16'h0000, setpoint_q};
                OFF_GAIN: s_axi_rdata <= {16'h0000, gain_q};
                OFF_TINT: s_axi_rdata <= {16'h0000, tint_q};
                OFF_LIFT: s_axi_rdata <= {16'h0000, lift_q};
                OFF_RAMP: s_axi_rdata <= {24'h000000, ramp_q};
                OFF_FFWD: s_axi_rdata <= {16'h0000, ffwd_q};
                OFF_BFTHR: s_axi_rdata <= {16'h0000, bfthr_q};
                OFF_ALARM: s_axi_rdata <= {30'h0, flag1_q, flag0_q};
                OFF_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_q};
                OFF_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_q};
                OFF_NV_CMD: s_axi_rdata <= {30'h0, nv_run_q, nv_pend_q};
                OFF_DRIVE: s_axi_rdata <= {16'h0000, drive_q};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10; // Unmapped address
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Two-flop synchronisers for outside inputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flow_s1_q <= 17'sd0;
            flow_s2_q <= 17'sd0;
            nv_busy_s1_q <= 1'b0;
            nv_busy_s2_q <= 1'b0;
        end
        else
        begin
            flow_s1_q <= flow_meas;
            flow_s2_q <= flow_s1_q;
            nv_busy_s1_q <= nv_busy;
            nv_busy_s2_q <= nv_busy_s1_q;
        end
    end

    // Fixed sample period tick
    assign tick = (smp_cnt_q == SMP_W'(SAMPLE_CYCLES - 1));
    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick)
            smp_cnt_q <= '0;
        else
            smp_cnt_q <= smp_cnt_q + 1'b1;
    end

    // PI controller, lift and feedforward summed, capped by the ramp level and clamped into the drive
    always_ff @(posedge aclk)
    begin
        logic signed [31:0] err, prop, sum, ff;
        err = 32'(signed'({1'b0, setpoint_q})) - 32'(flow_s2_q);
        prop = 32'((err * signed'({1'b0, gain_q})) >>> 8);
        ff = 32'(({16'h0000, setpoint_q} * {16'h0000, ffwd_q}) >> 16);
        if (!aresetn)
        begin
            integ_q <= 32'sd0;
            drive_q <= 16'h0000;
            ramp_lvl_q <= 16'h0000;
        end
        else if (tick)
        begin
            if (setpoint_q == 16'h0000)
            begin
                integ_q <= 32'sd0;
                ramp_lvl_q <= 16'h0000;
                drive_q <= 16'h0000;
            end
            else
            begin
                integ_q <= integ_q + err / signed'({16'h0000, (tint_q == 16'h0000) ? 16'h0001 : tint_q});
                // Rise from the lift at the opening ramp rate
                if (ramp_lvl_q < lift_q)
                    ramp_lvl_q <= lift_q;
                else if (ramp_lvl_q < FULL_SCALE - {8'h00, ramp_q})
                    ramp_lvl_q <= ramp_lvl_q + {8'h00, ramp_q};
                else
                    ramp_lvl_q <= FULL_SCALE;
                sum = prop + integ_q + 32'(lift_q) + ff;
                if (sum > signed'(32'(ramp_lvl_q)) && ramp_lvl_q != FULL_SCALE)
                    sum = 32'(ramp_lvl_q);
                if (sum < 0)
                    drive_q <= 16'h0000;
                else if (sum > 32'(FULL_SCALE))
                    drive_q <= FULL_SCALE;
                else
                    drive_q <= sum[15:0];
            end
        end
    end
    assign valve_drive = drive_q;

    // Backflow flags: bit 0 plain, bit 1 with threshold hysteresis
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !config_q[CFG_BF_EN])
        begin
            flag0_q <= 1'b0;
            flag1_q <= 1'b0;
        end
        else
        begin
            flag0_q <= flow_s2_q < 0;
            if (flow_s2_q < -17'(signed'({1'b0, bfthr_q})))
                flag1_q <= 1'b1;
            else if (flow_s2_q >= 17'sd0)
                flag1_q <= 1'b0;
        end
    end

    // Analog output, forced low in live-zero formats during backflow
    always_ff @(posedge aclk)
    begin
        logic [2:0] fmt;
        logic live;
        fmt = config_q[CFG_FMT_LSB +: CFG_FMT_W];
        live = (fmt == FMT_4_20MA) || (fmt == FMT_1_5V) || (fmt == FMT_2_10V);
        if (!aresetn)
            analog_out <= 16'h0000;
        else if (live && flag1_q)
            analog_out <= LIVE_ZERO_MIN >> 1;
        else if (live)
            analog_out <= LIVE_ZERO_MIN + 16'((({16'h0000, flow_s2_q[16] ? 16'h0000 : flow_s2_q[15:0]})
                          * {16'h0000, FULL_SCALE - LIVE_ZERO_MIN}) >> 16);
        else
            analog_out <= flow_s2_q[16] ? 16'h0000 : flow_s2_q[15:0];
    end

    // Non-volatile save sequencer
    assign persist_wr = wr_go && (awaddr_q == OFF_CONFIG || awaddr_q == OFF_GAIN ||
        awaddr_q == OFF_TINT || awaddr_q == OFF_LIFT || awaddr_q == OFF_RAMP ||
        awaddr_q == OFF_FFWD || awaddr_q == OFF_BFTHR);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nv_pend_q <= 1'b0;
            nv_run_q <= 1'b0;
            nv_idx_q <= 4'h0;
            nv_write <= 1'b0;
            nv_index <= 4'h0;
            nv_data <= 32'h0000_0000;
        end
        else
        begin
            nv_write <= 1'b0;
            if ((wr_go && awaddr_q == OFF_NV_CMD && wdata_q[NV_UPDATE]) ||
                (persist_wr && config_q[CFG_STORE_AUTO]))
                nv_pend_q <= 1'b1;
            if (!nv_run_q && nv_pend_q && !nv_busy_s2_q)
            begin
                nv_run_q <= 1'b1;
                nv_pend_q <= 1'b0;
                nv_idx_q <= 4'h0;
            end
            else if (nv_run_q && !nv_busy_s2_q && !nv_write)
            begin
                nv_write <= 1'b1;
                nv_index <= nv_idx_q;
                nv_data <= nv_word(nv_idx_q, config_q, gain_q, tint_q, lift_q, ramp_q,
                                   ffwd_q, bfthr_q);
                if (nv_idx_q == 4'(NV_COUNT - 2))
                    nv_run_q <= 1'b0;
                nv_idx_q <= nv_idx_q + 1'b1;
            end
        end
    end

    // Sticky interrupt status, set wins over write-one clear
    assign irq_ev[IRQ_BF] = flag1_q;
    assign irq_ev[IRQ_NV_DONE] = nv_write && (nv_index == 4'(NV_COUNT - 2));
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_q <= 2'b00;
        else if (wr_go && awaddr_q == OFF_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~wdata_q[1:0]) | irq_ev;
        else
            irq_stat_q <= irq_stat_q | irq_ev;
    end
    assign irq = |(irq_stat_q & irq_mask_q);
endmodule : flow_valve_control_backflow
`default_nettype wire

// file: bench/flow_valve_props.sv
// Checker of bus answers, save pulses, drive tick and the analog backflow level
// Assumes binding to the top module; config and threshold are shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none
module flow_valve_props
    import flow_valve_pkg::*;
#(
    parameter int SAMPLE_CYCLES = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic signed [16:0] flow_meas,
    input wire logic [15:0] valve_drive,
    input wire logic [15:0] analog_out,
    input wire logic nv_write,
    input wire logic [3:0] nv_index,
    input wire logic nv_busy
);
    logic [7:0] aw_q;
    logic [31:0] wd_q, cfg_q;
    logic [15:0] thr_q;
    logic [3:0] last_q;
    int gap_q;
    logic neg, live;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Live-zero format and flow below the negative threshold
    assign live = cfg_q[6:4] != FMT_0_20MA && cfg_q[6:4] <= FMT_2_10V;
    assign neg = flow_meas < -$signed({1'b0, thr_q});
    // Address and data of the write under way
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wd_q <= s_axi_wdata;
    end
    // Shadow registers, committed with the write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q <= RST_CONFIG;
            thr_q <= RST_BFTHR;
        end
        else if ($rose(s_axi_bvalid) && aw_q == OFF_CONFIG)
            cfg_q <= wd_q;
        else if ($rose(s_axi_bvalid) && aw_q == OFF_BFTHR)
            thr_q <= (wd_q > 32'h3333) ? BF_THR_MAX : wd_q[15:0];
    end
    // Last saved index and cycles since the drive last moved
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            last_q <= 4'h0;
            gap_q <= 0;
        end
        else
        begin
            last_q <= nv_write ? nv_index : last_q;
            gap_q <= $changed(valve_drive) ? 0 : gap_q + 1;
        end
    end
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid && s_axi_bresp == 2'b00) else $error("write not answered");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
    nv_pulse_a: assert property (
        nv_write |=> !nv_write) else $error("save pulse too long");
    nv_range_a: assert property (
        nv_write |-> nv_index <= 4'h6) else $error("save index out of range");
    nv_order_a: assert property (
        nv_write && nv_index != 4'h0 |-> nv_index == 4'(last_q + 4'h1))
        else $error("save index out of order");
    nv_stall_a: assert property (
        nv_busy [*5] |-> !nv_write) else $error("save while store busy");
    drive_tick_a: assert property (
        $changed(valve_drive) |-> gap_q >= SAMPLE_CYCLES - 1) else $error("drive off tick");
    analog_flag_a: assert property (
        (live && cfg_q[CFG_BF_EN] && neg) [*6] |-> analog_out == 16'h1999)
        else $error("analog not at backflow level");
endmodule : flow_valve_props
bind flow_valve_control_backflow flow_valve_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    u_flow_valve_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .flow_meas, .valve_drive, .analog_out, .nv_write,
    .nv_index, .nv_busy);
`default_nettype wire

// file: bench/flow_valve_partner.sv
// Model of the flow sensor and the non-volatile store beside the block
// Assumes the bench sets the flow value and whether the store answers slowly
`timescale 1ns/1ns
`default_nettype none
module flow_valve_partner
(
    input wire logic aclk,
    input wire logic signed [16:0] flow_set,
    input wire logic slow,
    input wire logic nv_write,
    input wire logic [3:0] nv_index,
    input wire logic [31:0] nv_data,
    output logic signed [16:0] flow_meas,
    output logic nv_busy
);
    logic [35:0] got_q[$];
    int busy_n;
    initial
    begin
        flow_meas = '0;
        nv_busy = 1'b0;
    end
    // Sensor follows the set flow; store logs each word and stays busy when slow
    always @(posedge aclk)
    begin
        flow_meas <= flow_set;
        if (nv_write)
        begin
            got_q.push_back({nv_index, nv_data});
            busy_n = slow ? 6 : 0;
        end
        else if (busy_n > 0)
            busy_n--;
        nv_busy <= busy_n > 0;
    end
endmodule : flow_valve_partner
`default_nettype wire

// file: bench/tb_flow_valve_control_backflow.sv
// Bench of the valve controller: bus tasks, register model and save log checks
// Assumes the partner model for flow and store, and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_flow_valve_control_backflow
    import flow_valve_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, nv_write, nv_busy, irq, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, nv_data, lf;
    logic [3:0] s_axi_wstrb, nv_index;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic signed [16:0] flow_meas, flow_set;
    logic [15:0] valve_drive, analog_out, thr, prv;
    logic [31:0] mdl [16];
    int err_total, samples_checked, cyc;
    flow_valve_control_backflow #(.SAMPLE_CYCLES(8)) u_flow_valve_control_backflow (.aclk,
        .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .flow_meas, .valve_drive, .analog_out, .nv_write,
        .nv_index, .nv_data, .nv_busy, .irq);
    flow_valve_partner u_flow_valve_partner (.aclk, .flow_set, .slow, .nv_write, .nv_index,
        .nv_data, .flow_meas, .nv_busy);
    // Clock of 10 ns
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Cycle ceiling against a hung handshake
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // Ramp setting from a measured value by bands
    function automatic logic [7:0] tune(input int m);
        if (m > 195)
            return 8'hff;
        return 8'(m <= 50 ? m * 2 : m <= 100 ? m * 3 / 2 : m * 13 / 10);
    endfunction : tune
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Write both channels together, release each when taken, wait for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad, wd;
        ad = 0;
        wd = 0;
        mdl[a[5:2]] = (a == OFF_BFTHR && d > 32'h3333) ? 32'h3333 : d;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            ad = ad || s_axi_awready;
            wd = wd || s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd_chk
    // Saved words against the model, in index order
    task automatic nv_chk(input int n);
        int i;
        i = 0;
        while (u_flow_valve_partner.got_q.size() < n && i < 600)
        begin
            @(posedge aclk);
            i++;
        end
        repeat (60) @(posedge aclk);
        chk(u_flow_valve_partner.got_q.size(), n);
        for (i = 0; i < n; i++)
        begin
            chk({28'h0, u_flow_valve_partner.got_q[i][35:32]}, i);
            chk(u_flow_valve_partner.got_q[i][31:0], mdl[i == 0 ? 0 : i + 1]);
        end
        u_flow_valve_partner.got_q.delete();
    endtask : nv_chk
    initial
    begin
        foreach (mdl[i])
            mdl[i] = '0;
        mdl[0] = RST_CONFIG;
        mdl[2] = 32'(RST_GAIN);
        mdl[3] = 32'(RST_TINT);
        {err_total, samples_checked, cyc} = '0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        flow_set = '0;
        lf = 32'hbc7d;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values and an unmapped read
        for (int i = 0; i < 4; i++)
            rd_chk({i[5:0], 2'b00}, mdl[i], 2'b00);
        rd_chk(8'h3c, 32'h0, 2'b10);
        // Drive from lift, ramp and feedforward with gain off
        wr(OFF_GAIN, 32'h0);
        wr(OFF_LIFT, 32'h0800);
        wr(OFF_RAMP, {24'h0, tune(42)});
        wr(OFF_FFWD, 32'h4000);
        flow_set <= 17'sh2000; // Flow at setpoint, so the PI error stays zero
        repeat (40) @(posedge aclk);
        chk({16'h0, valve_drive}, 32'h0);
        wr(OFF_SETPOINT, 32'h2000);
        prv = 16'h0;
        repeat (400)
        begin
            @(posedge aclk);
            if (valve_drive !== prv)
            begin
                chk(valve_drive, prv == 0 ? 16'h0800 : prv > 16'h0fac ? 16'h1000 : prv + 16'h54);
                prv = valve_drive;
            end
        end
        rd_chk(OFF_DRIVE, 32'h1000, 2'b00);
        wr(OFF_SETPOINT, 32'h0);
        repeat (40) @(posedge aclk);
        chk({16'h0, valve_drive}, 32'h0);
        wr(OFF_LIFT, 32'hf000);
        wr(OFF_RAMP, {24'h0, tune(200)});
        wr(OFF_FFWD, 32'hffff);
        wr(OFF_SETPOINT, 32'hffff);
        repeat (300) @(posedge aclk);
        chk({16'h0, valve_drive}, 32'hffff);
        wr(OFF_SETPOINT, 32'h0);
        repeat (40) @(posedge aclk);
        chk({16'h0, valve_drive}, 32'h0);
        repeat (100) @(posedge aclk);
        u_flow_valve_partner.got_q.delete();
        // Auto store, volatile holding, then the update command on a slow store
        lf = lfsr(lf);
        wr(OFF_GAIN, {16'h0, lf[15:0]});
        nv_chk(7);
        wr(OFF_CONFIG, 32'h10);
        repeat (100) @(posedge aclk);
        u_flow_valve_partner.got_q.delete();
        wr(OFF_TINT, 32'h20);
        nv_chk(0);
        slow <= 1'b1;
        wr(OFF_NV_CMD, 32'h1);
        nv_chk(7);
        rd_chk(OFF_IRQ_STAT, 32'h2, 2'b00);
        wr(OFF_IRQ_STAT, 32'h2);
        // Threshold clamp, then backflow in every output format
        lf = lfsr(lf);
        thr = {3'h0, lf[12:0]} | 16'h1;
        wr(OFF_BFTHR, 32'hffff);
        rd_chk(OFF_BFTHR, 32'h3333, 2'b00);
        wr(OFF_BFTHR, {16'h0, thr});
        rd_chk(OFF_BFTHR, {16'h0, thr}, 2'b00);
        wr(OFF_IRQ_MASK, 32'h1);
        for (int f = 0; f < 4; f++)
        begin
            wr(OFF_CONFIG, {25'h0, f[2:0], 4'h2});
            flow_set <= -$signed({1'b0, thr}) - 17'sd1;
            repeat (10) @(posedge aclk);
            rd_chk(OFF_ALARM, 32'h3, 2'b00);
            chk({31'h0, analog_out === 16'h1999}, {31'h0, f != 0});
            chk({31'h0, irq}, 32'h1);
            flow_set <= -17'sd1;
            repeat (10) @(posedge aclk);
            rd_chk(OFF_ALARM, 32'h3, 2'b00);
            flow_set <= '0;
            repeat (10) @(posedge aclk);
            rd_chk(OFF_ALARM, 32'h0, 2'b00);
            wr(OFF_IRQ_STAT, 32'h1);
            chk({31'h0, irq}, 32'h0);
        end
        // Masked event stays pending in status only
        wr(OFF_IRQ_MASK, 32'h0);
        flow_set <= -$signed({1'b0, thr}) - 17'sd1;
        repeat (10) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFF_IRQ_STAT, 32'h1, 2'b00);
        give_verdict();
    end
endmodule : tb_flow_valve_control_backflow
`default_nettype wire
